//--- rtl/exec_pkg.sv
// package for the shift, branch, bit and software interrupt executor
// assumes one core clock; the fetch path supplies decoded operations
// Summary of operation
// - a left shift moves the operand up one bit and puts zero in bit 0.
// - the shift puts old bit 15, or bit 7 in 8-bit width, into carry.
// - branch on bits clear is taken only if every selected bit is 0.
// - branch on bits set is taken only if every selected bit is 1.
// - branch on carry clear is taken only when carry is 0.
// - branch on carry set is taken only when carry is 1.
// - branch if equal is taken only when the zero flag is 1.
// - branch if nonzero is taken only when the zero flag is 0.
// - branch if minus is taken only when the negative flag is 1.
// - branch if plus is taken only when the negative flag is 0.
// - branch on overflow clear is taken only when overflow is 0.
// - branch on overflow set is taken only when overflow is 1.
// - a relative jump adds the offset; bank steps on carry or borrow.
// - soft interrupt: pc+2, push bank, pc and status, vector, bank 0.
// - clear memory bit writes 0 to selected bits and keeps the others.
package exec_pkg;
   // ==========================================================
   // operations
   typedef enum logic [3:0] {
      OP_NONE     = 4'h0, OP_SHL      = 4'h1, OP_BITS_CLR = 4'h2,
      OP_BITS_SET = 4'h3, OP_C_CLR    = 4'h4, OP_C_SET    = 4'h5,
      OP_Z_SET    = 4'h6, OP_Z_CLR    = 4'h7, OP_N_SET    = 4'h8,
      OP_N_CLR    = 4'h9, OP_V_CLR    = 4'ha, OP_V_SET    = 4'hb,
      OP_JMP      = 4'hc, OP_SOFT     = 4'hd, OP_CLRB     = 4'he
   } op_e;
   typedef enum logic [2:0] {
      ST_IDLE     = 3'h0, ST_P_BANK    = 3'h1, ST_P_CNT_HI  = 3'h2,
      ST_P_CNT_LO = 3'h3, ST_P_STAT_HI = 3'h4, ST_P_STAT_LO = 3'h5
   } st_e;
   // ==========================================================
   // constants
   localparam logic [15:0] SOFT_PC_STEP  = 16'h0002;
   localparam logic [7:0]  SOFT_BANK     = 8'h00;
   localparam logic [15:0] PC_RESET      = 16'h0000;
   localparam logic [15:0] SP_RESET      = 16'h01ff;
   localparam int          MSB_WIDE      = 15;
   localparam int          MSB_NARROW    = 7;
endpackage

//--- rtl/push_mem.sv
// stack memory written by the soft interrupt push sequence
// assumes writes and reads share the core clock
`timescale 1ns/1ps
module push_mem (
   // clock
   input  wire logic       clk,
   // write port
   input  wire logic       we,
   input  wire logic [7:0] waddr,
   input  wire logic [7:0] wdata,
   // read port, registered
   input  wire logic [7:0] raddr,
   output logic      [7:0] rdata
);
   logic [7:0] mem [256];
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule

//--- rtl/exec_unit.sv
// executor for shift, bit test/clear, branches and soft interrupt
// assumes op_valid is a one-cycle pulse, no new op while busy is high
`timescale 1ns/1ps
module exec_unit (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        arst_n,
   // operation request
   input  wire logic        op_valid,
   input  wire logic [3:0]  op_code,
   input  wire logic [15:0] operand,
   input  wire logic [15:0] bit_mask,
   input  wire logic [15:0] offset,
   input  wire logic        narrow_m,
   input  wire logic        len_next,
   // flags in
   input  wire logic        flag_c,
   input  wire logic        flag_z,
   input  wire logic        flag_n,
   input  wire logic        flag_v,
   // state in
   input  wire logic [15:0] status_in,
   input  wire logic [15:0] vector_in,
   input  wire logic [7:0]  stack_raddr,
   // results
   output logic [15:0]      result_ff,
   output logic             result_valid_ff,
   output logic             carry_out_ff,
   output logic             carry_we_ff,
   output logic             branch_taken_ff,
   output logic [15:0]      pc_ff,
   output logic [7:0]       bank_ff,
   output logic [15:0]      sp_ff,
   output logic             busy_ff,
   output logic [7:0]       stack_rdata
);
   typedef struct packed {
      exec_pkg::st_e st;
      logic [15:0]   res;
      logic          rv;
      logic          co;
      logic          cwe;
      logic          tk;
      logic [15:0]   pc;
      logic [7:0]    bank;
      logic [15:0]   sp;
      logic [15:0]   vec;
      logic [15:0]   stat;
      logic          bsy;
   } state_s;

   state_s st_ff;
   state_s nxt_st;
   logic          push_we;
   logic [7:0]    push_data;
   logic [15:0]   seq_pc;
   logic [16:0]   jsum;
   logic          cond;
   logic [15:0]   shl_val;
   logic          shl_c;

   // ==========================================================
   // combinational helpers
   always_comb begin
      // fall through address; len_next: 1 = three-byte form
      seq_pc  = st_ff.pc + (len_next ? 16'h0003 : 16'h0002);
      shl_val = {operand[14:0], 1'b0};
      shl_c   = narrow_m ? operand[exec_pkg::MSB_NARROW]
                         : operand[exec_pkg::MSB_WIDE];
      jsum    = {1'b0, st_ff.pc} + {1'b0, offset};
      case (exec_pkg::op_e'(op_code))
         exec_pkg::OP_BITS_CLR: cond = ~|(operand & bit_mask);
         exec_pkg::OP_BITS_SET: cond = &(operand | ~bit_mask);
         exec_pkg::OP_C_CLR:    cond = !flag_c;
         exec_pkg::OP_C_SET:    cond = flag_c;
         exec_pkg::OP_Z_SET:    cond = flag_z;
         exec_pkg::OP_Z_CLR:    cond = !flag_z;
         exec_pkg::OP_N_SET:    cond = flag_n;
         exec_pkg::OP_N_CLR:    cond = !flag_n;
         exec_pkg::OP_V_CLR:    cond = !flag_v;
         exec_pkg::OP_V_SET:    cond = flag_v;
         default:          cond = 1'b0;
      endcase
   end

   // ==========================================================
   // next state
   always_comb begin
      nxt_st     = st_ff;
      nxt_st.rv  = 1'b0;
      nxt_st.cwe = 1'b0;
      nxt_st.tk  = 1'b0;
      push_we    = 1'b0;
      push_data  = 8'h00;
      case (st_ff.st)
         exec_pkg::ST_IDLE: begin
            if (op_valid) begin
               case (exec_pkg::op_e'(op_code))
                  exec_pkg::OP_NONE: begin
                     nxt_st.pc = st_ff.pc;
                  end
                  exec_pkg::OP_SHL: begin
                     nxt_st.res = shl_val;
                     nxt_st.rv  = 1'b1;
                     nxt_st.co  = shl_c;
                     nxt_st.cwe = 1'b1;
                  end
                  exec_pkg::OP_CLRB: begin
                     nxt_st.res = operand & ~bit_mask;
                     nxt_st.rv  = 1'b1;
                  end
                  exec_pkg::OP_JMP: begin
                     nxt_st.pc = jsum[15:0];
                     nxt_st.tk = 1'b1;
                     // carry out of a forward step, borrow of a back step
                     if (!offset[15] && jsum[16]) begin
                        nxt_st.bank = st_ff.bank + 8'h01;
                     end else if (offset[15] && !jsum[16]) begin
                        nxt_st.bank = st_ff.bank - 8'h01;
                     end
                  end
                  exec_pkg::OP_SOFT: begin
                     nxt_st.pc   = st_ff.pc + exec_pkg::SOFT_PC_STEP;
                     nxt_st.vec  = vector_in;
                     nxt_st.stat = status_in;
                     nxt_st.bsy  = 1'b1;
                     nxt_st.st   = exec_pkg::ST_P_BANK;
                  end
                  default: begin
                     // conditional branches
                     nxt_st.tk = cond;
                     nxt_st.pc = cond ? seq_pc + offset : seq_pc;
                  end
               endcase
            end
         end
         exec_pkg::ST_P_BANK: begin
            push_we   = 1'b1;
            push_data = st_ff.bank;
            nxt_st.sp = st_ff.sp - 16'h0001;
            nxt_st.st = exec_pkg::ST_P_CNT_HI;
         end
         exec_pkg::ST_P_CNT_HI: begin
            push_we   = 1'b1;
            push_data = st_ff.pc[15:8];
            nxt_st.sp = st_ff.sp - 16'h0001;
            nxt_st.st = exec_pkg::ST_P_CNT_LO;
         end
         exec_pkg::ST_P_CNT_LO: begin
            push_we   = 1'b1;
            push_data = st_ff.pc[7:0];
            nxt_st.sp = st_ff.sp - 16'h0001;
            nxt_st.st = exec_pkg::ST_P_STAT_HI;
         end
         exec_pkg::ST_P_STAT_HI: begin
            push_we   = 1'b1;
            push_data = st_ff.stat[15:8];
            nxt_st.sp = st_ff.sp - 16'h0001;
            nxt_st.st = exec_pkg::ST_P_STAT_LO;
         end
         exec_pkg::ST_P_STAT_LO: begin
            push_we     = 1'b1;
            push_data   = st_ff.stat[7:0];
            nxt_st.sp   = st_ff.sp - 16'h0001;
            nxt_st.pc   = st_ff.vec;
            nxt_st.bank = exec_pkg::SOFT_BANK;
            nxt_st.tk   = 1'b1;
            nxt_st.bsy  = 1'b0;
            nxt_st.st   = exec_pkg::ST_IDLE;
         end
         default: begin
            nxt_st.st  = exec_pkg::ST_IDLE;
            nxt_st.bsy = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff      <= '0;
         st_ff.st   <= exec_pkg::ST_IDLE;
         st_ff.pc   <= exec_pkg::PC_RESET;
         st_ff.sp   <= exec_pkg::SP_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // stack only keeps the low byte of the pointer
   push_mem u_stack (
      .clk   (clk),
      .we    (push_we),
      .waddr (st_ff.sp[7:0]),
      .wdata (push_data),
      .raddr (stack_raddr),
      .rdata (stack_rdata)
   );

   always_comb begin
      result_ff       = st_ff.res;
      result_valid_ff = st_ff.rv;
      carry_out_ff    = st_ff.co;
      carry_we_ff     = st_ff.cwe;
      branch_taken_ff = st_ff.tk;
      pc_ff           = st_ff.pc;
      bank_ff         = st_ff.bank;
      sp_ff           = st_ff.sp;
      busy_ff         = st_ff.bsy;
   end

   // ==========================================================
   // checks
   a_shift_zero_in: assert property (@(posedge clk)
      disable iff (!arst_n)
      op_valid && !busy_ff && op_code == 4'h1 |=>
      result_ff[15:1] == $past(operand[14:0]) && !result_ff[0])
      else $error("shift result wrong");
   a_shift_carry: assert property (@(posedge clk)
      disable iff (!arst_n)
      op_valid && !busy_ff && op_code == 4'h1 |=>
      carry_out_ff == ($past(narrow_m) ? $past(operand[7])
                                       : $past(operand[15])))
      else $error("shift carry wrong");
   a_bits_clear_br: assert property (@(posedge clk)
      disable iff (!arst_n)
      op_valid && !busy_ff && op_code == 4'h2 |=>
      branch_taken_ff == (($past(operand) & $past(bit_mask)) == 16'h0000))
      else $error("bits clear branch wrong");
   a_bits_set_br: assert property (@(posedge clk)
      disable iff (!arst_n)
      op_valid && !busy_ff && op_code == 4'h3 |=>
      branch_taken_ff ==
      (($past(operand) & $past(bit_mask)) == $past(bit_mask)))
      else $error("bits set branch wrong");
   a_carry_clear_br: assert property (@(posedge clk)
      disable iff (!arst_n)
      op_valid && !busy_ff && op_code == 4'h4 |=>
      branch_taken_ff == !$past(flag_c))
      else $error("carry clear branch wrong");
   a_equal_br: assert property (@(posedge clk)
      disable iff (!arst_n)
      op_valid && !busy_ff && op_code == 4'h6 |=>
      branch_taken_ff == $past(flag_z))
      else $error("equal branch wrong");
   a_clear_bits: assert property (@(posedge clk)
      disable iff (!arst_n)
      op_valid && !busy_ff && op_code == 4'he |=>
      (result_ff & $past(bit_mask)) == 16'h0000 &&
      (result_ff | $past(bit_mask)) == ($past(operand) | $past(bit_mask)))
      else $error("bit clear wrong");
   a_soft_sequence: assert property (@(posedge clk)
      disable iff (!arst_n)
      op_valid && !busy_ff && op_code == 4'hd |=> busy_ff [*5] ##1
      (!busy_ff && bank_ff == 8'h00 && pc_ff == $past(vector_in, 6) &&
       sp_ff == $past(sp_ff, 6) - 16'h0005))
      else $error("soft interrupt sequence wrong");
   c_soft: cover property (@(posedge clk) op_valid && op_code == 4'hd);
   c_jump_carry: cover property (@(posedge clk)
      op_valid && op_code == 4'hc && jsum[16] && !offset[15]);
   c_branch_taken: cover property (@(posedge clk) branch_taken_ff);
endmodule

//--- bench/cpu_shift_branch_bit_ops_tb.sv
// bench for exec_unit: shift, bit ops, branches, jump, soft interrupt
// assumes exec_pkg compiled first; expectations come from a bench model
`timescale 1ns/1ps
module cpu_shift_branch_bit_ops_tb;
   logic        clk, arst_n, op_valid, narrow_m, len_next;
   logic        flag_c, flag_z, flag_n, flag_v;
   logic [3:0]  op_code;
   logic [15:0] operand, bit_mask, offset, status_in, vector_in;
   logic [7:0]  stack_raddr;
   logic [15:0] result_ff, pc_ff, sp_ff;
   logic        result_valid_ff, carry_out_ff, carry_we_ff;
   logic        branch_taken_ff, busy_ff;
   logic [7:0]  bank_ff, stack_rdata;
   int          failures, check_count;
   logic [31:0] seed;
   logic [15:0] m_pc, m_sp;
   logic [7:0]  m_bank;
   logic [7:0]  m_stk[$];

   exec_unit u_dut (.clk(clk), .arst_n(arst_n), .op_valid(op_valid),
      .op_code(op_code), .operand(operand), .bit_mask(bit_mask),
      .offset(offset), .narrow_m(narrow_m), .len_next(len_next),
      .flag_c(flag_c), .flag_z(flag_z), .flag_n(flag_n), .flag_v(flag_v),
      .status_in(status_in), .vector_in(vector_in),
      .stack_raddr(stack_raddr), .result_ff(result_ff),
      .result_valid_ff(result_valid_ff), .carry_out_ff(carry_out_ff),
      .carry_we_ff(carry_we_ff), .branch_taken_ff(branch_taken_ff),
      .pc_ff(pc_ff), .bank_ff(bank_ff), .sp_ff(sp_ff), .busy_ff(busy_ff),
      .stack_rdata(stack_rdata));

   // ==========================================================
   // helpers
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   function automatic logic [15:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[15:0];
   endfunction

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // one idle cycle before each op keeps op_valid to one write per step
   task automatic issue(input logic [3:0] code);
      @(posedge clk);
      #1;
      op_code = code;
      op_valid = 1'b1;
      @(posedge clk);
      #1;
      op_valid = 1'b0;
   endtask

   function automatic logic cond_of(input logic [3:0] c);
      case (c)
         4'h2: return (operand & bit_mask) == 16'h0000;
         4'h3: return (operand & bit_mask) == bit_mask;
         4'h4: return !flag_c;
         4'h5: return flag_c;
         4'h6: return flag_z;
         4'h7: return !flag_z;
         4'h8: return flag_n;
         4'h9: return !flag_n;
         4'ha: return !flag_v;
         default: return flag_v;
      endcase
   endfunction

   // ==========================================================
   // main sequence
   initial begin
      logic [16:0] s;
      logic [15:0] fall;
      logic [15:0] keep;
      logic        cnd;
      int          n;
      seed = 32'h18de;
      {op_valid, narrow_m, len_next, flag_c, flag_z, flag_n, flag_v} = '0;
      {op_code, operand, bit_mask, offset, status_in, vector_in} = '0;
      stack_raddr = 8'h00;
      failures = 0;
      check_count = 0;
      arst_n = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      arst_n = 1'b1;
      m_pc = 16'h0000;
      m_sp = 16'h01ff;
      m_bank = 8'h00;
      check({pc_ff, sp_ff, bank_ff, busy_ff}, {m_pc, m_sp, m_bank, 1'b0});
      issue(4'h0);
      check({pc_ff, branch_taken_ff, result_valid_ff}, {m_pc, 2'b00});
      for (int i = 0; i < 16; i++) begin
         operand = rnd();
         bit_mask = rnd();
         narrow_m = ^rnd();
         issue(i[0] ? 4'h1 : 4'he);
         keep = {{8{!narrow_m}}, 8'hff};
         cnd = narrow_m ? operand[7] : operand[15];
         if (i[0]) begin
            check(result_ff & keep, {operand[14:0], 1'b0} & keep);
            check({carry_out_ff, carry_we_ff}, {cnd, 1'b1});
         end else begin
            check(result_ff, operand & ~bit_mask);
            check(carry_we_ff, 1'b0);
         end
         check(result_valid_ff, 1'b1);
      end
      for (int i = 0; i < 40; i++) begin
         for (int c = 2; c <= 11; c++) begin
            {flag_c, flag_z, flag_n, flag_v, len_next} = 5'(rnd());
            bit_mask = rnd();
            operand = i[0] ? rnd() : (i[1] ? bit_mask : ~bit_mask);
            offset = rnd();
            cnd = cond_of(c[3:0]);
            fall = m_pc + (len_next ? 16'h0003 : 16'h0002);
            issue(c[3:0]);
            m_pc = cnd ? fall + offset : fall;
            case (c)
               2, 3:    check(branch_taken_ff, cnd);
               4, 5:    check(branch_taken_ff, cnd);
               6, 7:    check(branch_taken_ff, cnd);
               8, 9:    check(branch_taken_ff, cnd);
               default: check(branch_taken_ff, cnd);
            endcase
            check(pc_ff, m_pc);
         end
         offset = rnd();
         s = {1'b0, m_pc} + {1'b0, offset};
         if (!offset[15] && s[16]) m_bank++;
         else if (offset[15] && !s[16]) m_bank--;
         m_pc = s[15:0];
         issue(4'hc);
         check(pc_ff, m_pc);
         check({bank_ff, branch_taken_ff}, {m_bank, 1'b1});
      end
      for (int k = 0; k < 2; k++) begin
         status_in = rnd();
         vector_in = rnd();
         m_pc = m_pc + 16'h0002;
         m_stk = {m_bank, m_pc[15:8], m_pc[7:0], status_in[15:8],
            status_in[7:0]};
         issue(4'hd);
         check({pc_ff, busy_ff}, {m_pc, 1'b1});
         // a jump while busy must be dropped, or pc and bank go wrong
         offset = 16'h0100;
         issue(4'hc);
         n = 0;
         while (busy_ff === 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
         end
         m_pc = vector_in;
         m_bank = 8'h00;
         check(pc_ff, m_pc);
         check({bank_ff, branch_taken_ff}, {m_bank, 1'b1});
         check(sp_ff, m_sp - 16'h0005);
         for (int j = 0; j < 5; j++) begin
            stack_raddr = m_sp[7:0] - j[7:0];
            @(posedge clk);
            #1;
            check(stack_rdata, m_stk[j]);
         end
         m_sp = m_sp - 16'h0005;
      end
      final_report();
   end

   // ==========================================================
   // watchdog
   initial begin
      #(100 * 5000);
      failures++;
      final_report();
   end
endmodule
